// ---- hw/os_filter_pkg.sv ----
// Purpose: Shared constants for the oversampling averaging filter
// Assumes: 50 MHz system clock, 14-bit two's complement samples
// Notes: Ratio codes and rates as seen by the host on the select pins
package os_filter_pkg;
	localparam int num_channels = 8;
	localparam int sample_width = 14;
	localparam int sel_width = 3;
	localparam int max_shift = 6;
	localparam int acc_width = sample_width + max_shift;
	localparam logic [2:0] sel_no_os = 3'h0;
	localparam logic [2:0] sel_max = 3'h6;
	localparam logic [2:0] sel_invalid = 3'h7;
	// Base rate is 200 kSPS, so one sample period is 5000 ns
	localparam int clk_period_ns = 20;
	localparam int sample_period_ns = 5000;
	localparam int sample_period_cycles = sample_period_ns / clk_period_ns;
	localparam int fifo_depth = 8;
	localparam int word_width = num_channels * sample_width;
	typedef enum logic [1:0] {st_idle, st_wait, st_strobe, st_done} state_t;
endpackage

// ---- hw/oversampling_average_filter.sv ----
// Purpose: Per-channel averaging and decimation of converter samples
// Assumes: Sample inputs are valid when sample_valid is high
// Notes: Results pass through a FIFO before reaching the reader
//
// Contract
// - Code 000 gives one sample per start
// - Codes 001..110 give ratios 2 to 64
// - Throughput is 200 kSPS over ratio
// - First sample taken on start rising edge
// - Further samples launched by internal strobe
// - Average set, decimate to 14 bits
// - Eight channels averaged independently
// - Range pin picks 10 V or 5 V span
// - Results are two's complement, same format
`timescale 1ns/1ps
`default_nettype none
module oversampling_average_filter
	import os_filter_pkg::*;
#(
	parameter int channels = num_channels,
	parameter int period_cycles = sample_period_cycles
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Host pins
	input wire logic conversion_start_a,
	input wire logic conversion_start_b,
	input wire logic [sel_width-1:0] oversample_select,
	input wire logic range_select,
	// Converter core
	output logic sample_strobe,
	output logic range_10v,
	input wire logic sample_valid,
	input wire logic [channels*sample_width-1:0] sample_data,
	// Result stream
	output logic result_valid,
	input wire logic result_ready,
	output logic [channels*sample_width-1:0] result_data,
	output logic busy
);
	localparam int ww = channels * sample_width;

	// Ratio as shift count; 111 is undefined and treated as no averaging
	function automatic logic [2:0] ratio_shift(input logic [2:0] sel);
		return (sel > sel_max) ? 3'h0 : sel;
	endfunction

	state_t state_q;
	logic start_q;
	logic start_rise;
	logic [2:0] shift_q;
	logic [6:0] remain_q;
	logic [15:0] gap_q;
	logic signed [acc_width-1:0] acc_q [channels];
	logic [ww-1:0] avg_d;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [ww-1:0] fifo_out_data;

	//----------------------------------------
	// Start edge detection
	//----------------------------------------
	// both start pins high now, not both high last cycle
	assign start_rise = conversion_start_a && conversion_start_b && !start_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			start_q <= 1'b0;
		end else begin
			start_q <= conversion_start_a && conversion_start_b;
		end
	end

	//----------------------------------------
	// Sequencer
	//----------------------------------------
	// Starts arriving while busy are dropped; the host must pace them.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= st_idle;
			shift_q <= 3'h0;
			remain_q <= 7'h0;
			gap_q <= 16'h0;
			sample_strobe <= 1'b0;
			busy <= 1'b0;
		end else begin
			sample_strobe <= 1'b0;
			case (state_q)
				st_idle: begin
					if (start_rise) begin
						shift_q <= ratio_shift(oversample_select);
						remain_q <= 7'(1 << ratio_shift(oversample_select));
						sample_strobe <= 1'b1;
						busy <= 1'b1;
						state_q <= st_wait;
					end
				end
				st_wait: begin
					if (sample_valid) begin
						remain_q <= remain_q - 7'h1;
						gap_q <= 16'(period_cycles - 1);
						state_q <= (remain_q == 7'h1) ? st_done : st_strobe;
					end
				end
				st_strobe: begin
					// internal strobe paced at base rate
					if (gap_q == 16'h0) begin
						sample_strobe <= 1'b1;
						state_q <= st_wait;
					end else begin
						gap_q <= gap_q - 16'h1;
					end
				end
				st_done: begin
					if (fifo_in_ready) begin
						busy <= 1'b0;
						state_q <= st_idle;
					end
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	//----------------------------------------
	// Accumulators
	//----------------------------------------
	always_ff @(posedge clk) begin
		for (int i = 0; i < channels; i++) begin
			if (reset) begin
				acc_q[i] <= '0;
			end else if (state_q == st_idle && start_rise) begin
				acc_q[i] <= '0;
			end else if (state_q == st_wait && sample_valid) begin
				acc_q[i] <= acc_q[i] + acc_width'(signed'(
					sample_data[i*sample_width +: sample_width]));
			end
		end
	end

	always_comb begin
		avg_d = '0;
		for (int i = 0; i < channels; i++) begin
			avg_d[i*sample_width +: sample_width] =
				sample_width'(acc_q[i] >>> shift_q);
		end
	end

	//----------------------------------------
	// Result staging into the FIFO
	//----------------------------------------
	// Sums are settled in st_done, so the live average is pushed directly
	assign fifo_in_valid = (state_q == st_done);

	word_fifo #(
		.width(ww),
		.depth(fifo_depth)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(avg_d),
		.out_valid(fifo_out_valid),
		.out_ready(result_ready && result_valid),
		.out_data(fifo_out_data)
	);

	//----------------------------------------
	// Registered outputs
	//----------------------------------------
	// One-word skid: output register loads when empty or being taken.
	always_ff @(posedge clk) begin
		if (reset) begin
			result_valid <= 1'b0;
			result_data <= '0;
			range_10v <= 1'b0;
		end else begin
			range_10v <= range_select;
			if (!result_valid || result_ready) begin
				result_valid <= fifo_out_valid && !(result_valid && result_ready);
				result_data <= fifo_out_data;
			end
		end
	end

	//----------------------------------------
	// Checks
	//----------------------------------------
	property p_strobe_on_start;
		@(posedge clk) disable iff (reset)
		(state_q == st_idle && start_rise) |=> sample_strobe && busy;
	endproperty
	a_strobe_on_start: assert property (p_strobe_on_start)
		else $error("no strobe after start edge");

	property p_no_os_one_sample;
		@(posedge clk) disable iff (reset)
		(state_q == st_idle && start_rise && oversample_select == sel_no_os)
		|=> remain_q == 7'h1;
	endproperty
	a_no_os_one_sample: assert property (p_no_os_one_sample)
		else $error("code 000 did not request one sample");

	property p_ratio;
		@(posedge clk) disable iff (reset)
		(state_q == st_idle && start_rise && oversample_select <= sel_max)
		|=> remain_q == 7'(1 << $past(oversample_select));
	endproperty
	a_ratio: assert property (p_ratio)
		else $error("ratio does not match select code");

	property p_strobe_gap;
		@(posedge clk) disable iff (reset)
		(state_q == st_wait && sample_valid && remain_q != 7'h1)
		|=> !sample_strobe [*2];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap)
		else $error("internal strobe too soon");

	property p_clear;
		@(posedge clk) disable iff (reset)
		(state_q == st_idle && start_rise) |=> acc_q[0] == '0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("accumulator not cleared on start");

	property p_range;
		@(posedge clk) disable iff (reset)
		range_select |=> range_10v;
	endproperty
	a_range: assert property (p_range)
		else $error("range output does not follow pin");

	property p_internal;
		@(posedge clk) disable iff (reset)
		(sample_strobe && !$past(start_rise)) |-> $past(state_q) == st_strobe;
	endproperty
	a_internal: assert property (p_internal)
		else $error("strobe without start or pacing");

	property p_avg_one;
		@(posedge clk) disable iff (reset)
		(state_q == st_done && shift_q == 3'h0)
		|-> avg_d[sample_width-1:0] == acc_q[0][sample_width-1:0];
	endproperty
	a_avg_one: assert property (p_avg_one)
		else $error("ratio one result differs from sample");

	property p_done_pushes;
		@(posedge clk) disable iff (reset)
		(state_q == st_done && fifo_in_ready) |=> state_q == st_idle && !busy;
	endproperty
	a_done_pushes: assert property (p_done_pushes)
		else $error("result not handed on");
endmodule
`default_nettype wire

// ---- hw/word_fifo.sv ----
// Purpose: Small flip-flop FIFO with valid and ready on both sides
// Assumes: Depth is a power of two
// Notes: Full and empty follow an occupancy counter
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int width = 112,
	parameter int depth = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [width-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [width-1:0] out_data
);
	localparam int aw = $clog2(depth);
	logic [width-1:0] mem_q [depth];
	logic [aw-1:0] wr_q;
	logic [aw-1:0] rd_q;
	logic [aw:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != (aw+1)'(depth));
	assign out_valid = (count_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/core_model.sv ----
// Purpose: Converter core stand-in answering each sample strobe
// Assumes: One strobe is outstanding at a time
// Notes: Data toggles while not valid so stale words never pass
`timescale 1ns/1ps
`default_nettype none
module core_model
	import os_filter_pkg::*;
(
	// Clock and pacing
	input wire logic clk,
	input wire logic sample_strobe,
	input wire logic slow,
	// Sample answer
	output logic sample_valid,
	output logic [word_width-1:0] sample_data
);
	initial begin
		sample_valid = 1'b0;
		sample_data = '0;
		forever begin
			@(posedge clk);
			sample_valid <= 1'b0;
			sample_data <= ~sample_data;
			if (sample_strobe === 1'b1) begin
				repeat (slow ? 6 : 0) begin
					@(posedge clk);
					sample_data <= ~sample_data;
				end
				// Fresh words only on the answering edge, no double drive
				@(posedge clk);
				sample_valid <= 1'b1;
				for (int i = 0; i < num_channels; i++) begin
					sample_data[i*sample_width+:sample_width] <= 14'($urandom);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/oversampling_average_filter_tb_top.sv ----
// Purpose: Self-checking bench for the averaging filter
// Assumes: Sample period shortened to 4 cycles
// Notes: Expected averages come from the core model's samples
`timescale 1ns/1ps
`default_nettype none
module oversampling_average_filter_tb_top;
	import os_filter_pkg::*;
	localparam int per = 4;
	logic clk = 0, reset = 1, slow = 0, hold = 0;
	logic conversion_start_a = 0, conversion_start_b = 0, range_select = 0;
	logic [2:0] oversample_select = '0;
	logic sample_strobe, range_10v, sample_valid, result_valid, busy;
	logic result_ready = 0, rs_prev = 0, live = 0;
	logic [word_width-1:0] sample_data, result_data, exp_w;
	logic [word_width-1:0] exp_q[$];
	int num_errors = 0, checked = 0, cycles = 0, strobes = 0, gap = 0;
	int acc[num_channels], cnt = 0, shift = 0;
	always #10 clk = ~clk;
	oversampling_average_filter #(.period_cycles(per)) dut (.clk, .reset,
		.conversion_start_a, .conversion_start_b, .oversample_select,
		.range_select, .sample_strobe, .range_10v, .sample_valid,
		.sample_data, .result_valid, .result_ready, .result_data, .busy);
	core_model model (.clk, .sample_strobe, .slow, .sample_valid,
		.sample_data);
	task automatic check(input logic [word_width-1:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic run_set(input logic [2:0] sel, input logic slw);
		int base;
		wait_idle();
		// host paces starts, never code 111
		repeat (per) @(posedge clk);
		base = strobes;
		shift = sel;
		oversample_select <= sel;
		slow <= slw;
		range_select <= 1'($urandom);
		conversion_start_a <= 1'b1;
		conversion_start_b <= 1'b1;
		@(posedge clk);
		conversion_start_a <= 1'b0;
		conversion_start_b <= 1'b0;
		// A second start while busy must add no result
		repeat (2) @(posedge clk);
		check(word_width'(busy), word_width'(1));
		conversion_start_a <= 1'b1;
		conversion_start_b <= 1'b1;
		@(posedge clk);
		conversion_start_a <= 1'b0;
		conversion_start_b <= 1'b0;
		wait_idle();
		repeat (2) @(posedge clk);
		check(word_width'(strobes - base), word_width'(1 << sel));
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			end_sim();
		end
		result_ready <= !hold && 1'($urandom);
		rs_prev <= range_select;
		live <= !reset;
		if (live && !reset) check(word_width'(range_10v), word_width'(rs_prev));
		if (sample_strobe === 1'b1) begin
			strobes++;
			check(word_width'(gap >= per), word_width'(1));
		end
		gap = (sample_valid === 1'b1) ? 0 : gap + 1;
		if (sample_valid === 1'b1) begin
			for (int i = 0; i < num_channels; i++) begin
				acc[i] += int'(signed'(sample_data[i*sample_width+:sample_width]));
			end
			cnt++;
			if (cnt == (1 << shift)) begin
				// Sums restart per set so sets never mix
				for (int i = 0; i < num_channels; i++) begin
					exp_w[i*sample_width+:sample_width] = 14'(acc[i] >>> shift);
					acc[i] = 0;
				end
				cnt = 0;
				exp_q.push_back(exp_w);
			end
		end
		if (result_valid === 1'b1 && result_ready === 1'b1) begin
			if (exp_q.size() > 0) check(result_data, exp_q.pop_front());
			else check(result_data, 'x);
		end
	end
	initial begin
		void'($urandom(29200));
		for (int i = 0; i < num_channels; i++) acc[i] = 0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < 14; k++) run_set(3'(k % 7), 1'($urandom));
		repeat (40) @(posedge clk);
		check(word_width'(exp_q.size()), '0);
		hold <= 1'b1;
		for (int k = 0; k < fifo_depth; k++) run_set(3'h0, 1'b0);
		check(word_width'(result_valid), word_width'(1));
		hold <= 1'b0;
		repeat (200) @(posedge clk);
		check(word_width'(exp_q.size()), '0);
		check(word_width'(result_valid), '0);
		end_sim();
	end
endmodule
`default_nettype wire
